/* hw/light_regs_consts.vh */
// register indices, field layout, reset values and timing for the
// light settings and distance status register bank
// byte address on the bus is four times each index
`ifndef LIGHT_REGS_CONSTS_VH
`define LIGHT_REGS_CONSTS_VH

`define IDX_LIGHT_CTRL 10'h038
`define IDX_UPPER_LIMIT 10'h03A
`define IDX_LOWER_LIMIT 10'h03C
`define IDX_REPEAT_DELAY 10'h03E
`define IDX_GAIN_SELECT 10'h03F
`define IDX_EXPOSURE_TIME 10'h040
`define IDX_DISTANCE_STATUS 10'h04D
`define IDX_LIGHT_EVENT 10'h04F
`define IDX_LIGHT_VALUE 10'h050
`define IDX_IRQ_STATUS 10'h070
`define IDX_IRQ_CLEAR 10'h071
`define IDX_IRQ_ENABLE 10'h072

`define RST_UPPER_LIMIT 16'hFFFF
`define RST_LOWER_LIMIT 16'h0000
`define RST_REPEAT_DELAY 8'hFF
`define RST_GAIN_SELECT 3'h6
`define RST_EXPOSURE_TIME 9'h000
`define RST_ERROR_CODE 4'h0

`define CTRL_START_BIT 0
`define CTRL_MODE_BIT 1
`define CTRL_EVSEL_LO 2
`define CTRL_EVSEL_HI 3
`define EVENT_FIELD_LO 3
`define EVENT_FIELD_HI 5

`define ERR_NONE 4'h0
`define ERR_UNUSED_A 4'h9
`define ERR_UNUSED_B 4'hA

`define EVT_NONE 3'h0
`define EVT_LEVEL_LOW 3'h1
`define EVT_LEVEL_HIGH 3'h2
`define EVT_OUT_WINDOW 3'h3
`define EVT_NEW_SAMPLE 3'h4

`define IRQ_BIT_LOW 0
`define IRQ_BIT_HIGH 1
`define IRQ_BIT_WINDOW 2
`define IRQ_BIT_SAMPLE 3

`define CLK_PERIOD_NS 50
`define MS_NS 1000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define DELAY_STEP_MS 10

`endif

/* hw/light_sequencer.v */
// light measurement sequencer: integration then optional repeat delay
// assumes a free running pclk and a front end count valid at integration end
`timescale 1ns/1ps
`default_nettype none
`include "light_regs_consts.vh"
module light_sequencer #(
  parameter MS_CYCLES = `MS_CYCLES
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire start,
  input wire continuous,
  input wire [8:0] expo_code,
  input wire [7:0] delay_code,
  // front end
  input wire [15:0] sample_in,
  // results
  output reg integrating,
  output reg sample_done,
  output reg [15:0] sample_out
);
  localparam S_IDLE = 2'd0;
  localparam S_INTEG = 2'd1;
  localparam S_WAIT = 2'd2;
  reg [1:0] state;
  reg [31:0] pre;
  reg [11:0] ms;
  wire tick = (pre == MS_CYCLES - 1);
  wire [11:0] integ_ms = {3'b000, expo_code} + 12'h001;
  wire [11:0] wait_ms = ({4'h0, delay_code} + 12'h001) * 12'd10;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
      pre <= 32'h0;
      ms <= 12'h000;
      integrating <= 1'b0;
      sample_done <= 1'b0;
      sample_out <= 16'h0000;
    end
    else
    begin
      sample_done <= 1'b0;
      pre <= tick ? 32'h0 : pre + 32'h1;
      case (state)
        S_IDLE:
        begin
          pre <= 32'h0;
          ms <= 12'h000;
          if (start)
          begin
            state <= S_INTEG;
            integrating <= 1'b1;
          end
        end
        S_INTEG:
        begin
          if (start && continuous)
          begin
            state <= S_IDLE;
            integrating <= 1'b0;
          end
          else if (tick)
          begin
            ms <= ms + 12'h001;
            if (ms + 12'h001 >= integ_ms)
            begin
              ms <= 12'h000;
              sample_out <= sample_in;
              sample_done <= 1'b1;
              integrating <= 1'b0;
              state <= continuous ? S_WAIT : S_IDLE;
            end
          end
        end
        S_WAIT:
        begin
          if (start)
            state <= S_IDLE;
          else if (tick)
          begin
            ms <= ms + 12'h001;
            if (ms + 12'h001 >= wait_ms)
            begin
              ms <= 12'h000;
              integrating <= 1'b1;
              state <= S_INTEG;
            end
          end
        end
        default:
        begin
          state <= S_IDLE;
          integrating <= 1'b0;
        end
      endcase
    end
  end
endmodule // light_sequencer
`default_nettype wire

/* hw/als_config_range_status_regs.v */
// light measurement settings and distance status registers on APB
// assumes APB master on pclk; front end count and ranging state as inputs
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "light_regs_consts.vh"
module als_config_range_status_regs #(
  parameter MS_CYCLES = `MS_CYCLES
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // light front end
  input wire [15:0] light_sample,
  output reg [2:0] light_gain,
  output wire light_integrating,
  // ranging engine
  input wire [3:0] range_error_code,
  input wire range_busy,
  // interrupt
  output reg irq
);
  reg [15:0] light_upper_limit;
  reg [15:0] light_lower_limit;
  reg [7:0] light_repeat_delay;
  reg [8:0] light_exposure_time;
  reg light_mode;
  reg [1:0] event_select;
  reg start_pulse;
  reg [3:0] error_code;
  reg range_ready;
  reg [2:0] light_event;
  reg [3:0] irq_status;
  reg [3:0] irq_enable;
  reg [31:0] next_rdata;
  reg next_err;
  reg [3:0] set_bits;
  reg [3:0] clr_bits;
  wire sample_done;
  wire [15:0] sample_value;
  wire [9:0] index = paddr[11:2];
  wire access = psel && penable && !pready;
  wire wr_now = psel && penable && pready && pwrite;

  // true when the register index is on the map
  function mapped;
    input [9:0] idx;
    begin
      case (idx)
        `IDX_LIGHT_CTRL, `IDX_UPPER_LIMIT, `IDX_LOWER_LIMIT,
        `IDX_REPEAT_DELAY, `IDX_GAIN_SELECT, `IDX_EXPOSURE_TIME,
        `IDX_DISTANCE_STATUS, `IDX_LIGHT_EVENT, `IDX_LIGHT_VALUE,
        `IDX_IRQ_STATUS, `IDX_IRQ_CLEAR, `IDX_IRQ_ENABLE:
          mapped = 1'b1;
        default:
          mapped = 1'b0;
      endcase
    end
  endfunction

  // unused codes are masked so software never sees them
  function [3:0] clean_error;
    input [3:0] code;
    begin
      if (code == `ERR_UNUSED_A || code == `ERR_UNUSED_B)
        clean_error = `ERR_NONE;
      else
        clean_error = code;
    end
  endfunction

  light_sequencer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_pulse),
    .continuous(light_mode),
    .expo_code(light_exposure_time),
    .delay_code(light_repeat_delay),
    .sample_in(light_sample),
    .integrating(light_integrating),
    .sample_done(sample_done),
    .sample_out(sample_value)
  );

  wire is_low = sample_value < light_lower_limit;
  wire is_high = sample_value > light_upper_limit;
  wire is_out = is_low || is_high;

  // apb read mux, registered so prdata comes from a flop
  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_err = !mapped(index);
    case (index)
      `IDX_LIGHT_CTRL:
        next_rdata = {28'h0, event_select, light_mode, 1'b0};
      `IDX_UPPER_LIMIT:
        next_rdata = {16'h0000, light_upper_limit};
      `IDX_LOWER_LIMIT:
        next_rdata = {16'h0000, light_lower_limit};
      `IDX_REPEAT_DELAY:
        next_rdata = {24'h0, light_repeat_delay};
      `IDX_GAIN_SELECT:
        next_rdata = {29'h0, light_gain};
      `IDX_EXPOSURE_TIME:
        next_rdata = {23'h0, light_exposure_time};
      // legacy bits 3..1 left at zero
      `IDX_DISTANCE_STATUS:
        next_rdata = {24'h0, error_code, 3'b000, range_ready};
      `IDX_LIGHT_EVENT:
        next_rdata = {26'h0, light_event, 3'b000};
      `IDX_LIGHT_VALUE:
        next_rdata = {16'h0000, sample_value};
      `IDX_IRQ_STATUS:
        next_rdata = {28'h0, irq_status};
      `IDX_IRQ_ENABLE:
        next_rdata = {28'h0, irq_enable};
      default:
        next_rdata = 32'h0000_0000;
    endcase
    if (pwrite)
      next_rdata = 32'h0000_0000;
  end

  // one wait state: pready rises the cycle after penable
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access;
      pslverr <= access && next_err;
      prdata <= access ? next_rdata : 32'h0000_0000;
    end
  end

  // configuration registers, written at the completing edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      light_upper_limit <= `RST_UPPER_LIMIT;
      light_lower_limit <= `RST_LOWER_LIMIT;
      light_repeat_delay <= `RST_REPEAT_DELAY;
      light_gain <= `RST_GAIN_SELECT;
      light_exposure_time <= `RST_EXPOSURE_TIME;
      light_mode <= 1'b0;
      event_select <= 2'b00;
      irq_enable <= 4'h0;
      start_pulse <= 1'b0;
    end
    else
    begin
      start_pulse <= 1'b0;
      if (wr_now)
      begin
        case (index)
          `IDX_LIGHT_CTRL:
          begin
            light_mode <= pwdata[`CTRL_MODE_BIT];
            event_select <= pwdata[`CTRL_EVSEL_HI:`CTRL_EVSEL_LO];
            // start ignored while ranging holds the device
            start_pulse <= pwdata[`CTRL_START_BIT] && !range_busy;
          end
          `IDX_UPPER_LIMIT:
            light_upper_limit <= pwdata[15:0];
          `IDX_LOWER_LIMIT:
            light_lower_limit <= pwdata[15:0];
          `IDX_REPEAT_DELAY:
            light_repeat_delay <= pwdata[7:0];
          `IDX_GAIN_SELECT:
            light_gain <= pwdata[2:0];
          `IDX_EXPOSURE_TIME:
            light_exposure_time <= pwdata[8:0];
          `IDX_IRQ_ENABLE:
            irq_enable <= pwdata[3:0];
          default:
            light_mode <= light_mode;
        endcase
      end
    end
  end

  // distance status follows the ranging engine one cycle late
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      error_code <= `RST_ERROR_CODE;
      range_ready <= 1'b1;
    end
    else
    begin
      error_code <= clean_error(range_error_code);
      // ready only when nothing is busy
      range_ready <= !range_busy && !light_integrating;
    end
  end

  // event field and sticky interrupt status
  always @*
  begin
    set_bits = 4'h0;
    if (sample_done)
    begin
      set_bits[`IRQ_BIT_LOW] = is_low;
      set_bits[`IRQ_BIT_HIGH] = is_high;
      set_bits[`IRQ_BIT_WINDOW] = is_out;
      set_bits[`IRQ_BIT_SAMPLE] = 1'b1;
    end
    clr_bits = 4'h0;
    if (wr_now && index == `IDX_IRQ_CLEAR)
      clr_bits = pwdata[3:0];
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      light_event <= `EVT_NONE;
      irq_status <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      // set wins over a clear in the same cycle
      irq_status <= (irq_status & ~clr_bits) | set_bits;
      irq <= |(((irq_status & ~clr_bits) | set_bits) & irq_enable);
      if (sample_done)
      begin
        case (event_select)
          2'd0:
            light_event <= is_low ? `EVT_LEVEL_LOW : `EVT_NONE;
          2'd1:
            light_event <= is_high ? `EVT_LEVEL_HIGH : `EVT_NONE;
          2'd2:
            light_event <= is_out ? `EVT_OUT_WINDOW : `EVT_NONE;
          default:
            light_event <= `EVT_NEW_SAMPLE;
        endcase
      end
    end
  end
endmodule // als_config_range_status_regs
`default_nettype wire

/* bench/light_regs_checker_assertions.sv */
// port assertions for the light settings and distance status bank
// bound to every instance of the bank, single pclk domain
`timescale 1ns/1ps
`default_nettype none
module light_regs_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // device side
  input wire logic [2:0] light_gain,
  input wire logic range_busy
);
  logic [31:0] wd_q;
  logic rd_ok;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // last write data, read back after the access edge
  always_ff @(posedge pclk) wd_q <= pwdata;
  assign rd_ok = pready && !pwrite && !pslverr;
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_IDLE: assert property (!(psel && penable) |=> !pready && !pslverr)
    else $error("answer without access");
  AST_UNMAPPED: assert property (pready |-> pslverr == !(paddr[11:2] inside {10'h038,
    10'h03A, 10'h03C, 10'h03E, 10'h03F, 10'h040, 10'h04D, 10'h04F, 10'h050, 10'h070,
    10'h071, 10'h072})) else $error("error flag wrong for address");
  AST_STATUS_BITS: assert property (rd_ok && paddr[11:2] == 10'h04D |-> prdata[31:8] == 0
    && prdata[3:1] == 0 && !(prdata[7:4] inside {4'h9, 4'hA}))
    else $error("distance status carries illegal bits");
  AST_GAIN_RSV: assert property (rd_ok && paddr[11:2] == 10'h03F |-> prdata[31:3] == 0)
    else $error("gain reserved bits not zero");
  AST_EXPO_RSV: assert property (rd_ok && paddr[11:2] == 10'h040 |-> prdata[31:9] == 0)
    else $error("exposure reserved bits not zero");
  AST_GAIN_PORT: assert property (pready && pwrite && paddr[11:2] == 10'h03F
    |=> light_gain == wd_q[2:0]) else $error("gain output not updated");
  AST_BUSY: assert property (rd_ok && paddr[11:2] == 10'h04D && $past(range_busy)
    && $past(range_busy, 2) && $past(range_busy, 3) |-> !prdata[0])
    else $error("ready shown while busy");
endmodule // light_regs_checker
bind als_config_range_status_regs light_regs_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .light_gain(light_gain),
  .range_busy(range_busy));
`default_nettype wire

/* bench/light_front_end.sv */
// light front end and ranging engine model facing the bank
// the count is only held near integration; otherwise it shows its inverse
`timescale 1ns/1ps
`default_nettype none
module light_front_end (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // settings from the bench
  input wire logic [15:0] level,
  input wire logic [3:0] err_set,
  input wire logic busy_set,
  // device side
  input wire logic light_integrating,
  output logic [15:0] light_sample,
  output logic [3:0] range_error_code,
  output logic range_busy
);
  logic integ_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      integ_q <= 1'b0;
      range_error_code <= 4'h0;
      range_busy <= 1'b0;
    end
    else
    begin
      integ_q <= light_integrating;
      range_error_code <= err_set;
      range_busy <= busy_set;
    end
  // no stale count outside the capture window
  assign light_sample = (light_integrating | integ_q) ? level : ~level;
endmodule // light_front_end
`default_nettype wire

/* bench/test_als_config_range_status_regs.sv */
// self-checking bench for the light settings and distance status bank
// apb master tasks, read expectations queued, one monitor compares
`timescale 1ns/1ps
`default_nettype none
module test_als_config_range_status_regs;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, integ, busy_set;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] level, sample;
  logic [3:0] err_set, err;
  logic [2:0] gain;
  logic busy, prev;
  logic [32:0] q[$];
  int mismatches, n_compared, n, i;
  initial
  begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  als_config_range_status_regs #(.MS_CYCLES(5)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .light_sample(sample),
    .light_gain(gain), .light_integrating(integ), .range_error_code(err),
    .range_busy(busy), .irq(irq));
  light_front_end u_fe (.pclk(pclk), .presetn(presetn), .level(level), .err_set(err_set),
    .busy_set(busy_set), .light_integrating(integ), .light_sample(sample),
    .range_error_code(err), .range_busy(busy));
  task check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && t++ < 20);
    // a missing answer counts against the run instead of hanging it
    if (pready !== 1'b1)
      mismatches++;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] exp);
    q.push_back(exp);
    apb(a, 0, 0);
  endtask
  task print_verdict;
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // read monitor: oldest expectation against the answer
  always @(posedge pclk)
    if (pready === 1'b1 && pwrite === 1'b0 && q.size() > 0)
      check({pslverr, prdata}, q.pop_front());
  initial
  begin
    #(40000 * 50);
    mismatches++;
    print_verdict;
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, busy_set, err_set} = 0;
    level = 16'h0300;
    presetn = 0;
    void'($urandom(45720));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    rd(12'h0E8, 33'h0FFFF);
    rd(12'h0F0, 33'h0);
    rd(12'h0F8, 33'h0FF);
    rd(12'h0FC, 33'h06);
    rd(12'h100, 33'h0);
    rd(12'h134, 33'h01);
    for (i = 0; i < 3; i++)
    begin
      r = $urandom;
      apb(12'h0E8 + 8 * i, 1, r);
      rd(12'h0E8 + 8 * i, i == 2 ? r[7:0] : r[15:0]);
    end
    apb(12'h100, 1, r);
    rd(12'h100, r[8:0]);
    for (i = 0; i < 8; i++)
    begin
      apb(12'h0FC, 1, 32'h40 | i);
      rd(12'h0FC, i);
      check(gain, i);
    end
    rd(12'h004, 33'h100000000);
    apb(12'h134, 1, 32'hFF);
    for (i = 0; i < 16; i++)
    begin
      err_set <= i;
      repeat (2) @(posedge pclk);
      rd(12'h134, {(i == 9 || i == 10) ? 4'h0 : i[3:0], 4'h1});
    end
    busy_set <= 1;
    repeat (4) @(posedge pclk);
    rd(12'h134, 33'hF0);
    busy_set <= 0;
    apb(12'h0F0, 1, 32'h100);
    apb(12'h0E8, 1, 32'h200);
    apb(12'h100, 1, 32'h63);
    apb(12'h1C8, 1, 32'h2);
    apb(12'h0E0, 1, 32'h5);
    n = 0;
    while (irq !== 1'b1 && n++ < 1000) @(posedge pclk);
    check(irq, 1);
    rd(12'h140, 33'h300);
    rd(12'h13C, 33'h10);
    rd(12'h1C0, 33'hE);
    apb(12'h1C4, 1, 32'hF);
    @(posedge pclk);
    check(irq, 0);
    apb(12'h1C8, 1, 32'h0);
    apb(12'h100, 1, 32'h0);
    apb(12'h0F8, 1, 32'h0);
    apb(12'h0E0, 1, 32'h3);
    n = 0;
    prev = 0;
    for (i = 0; i < 150; i++)
    begin
      @(posedge pclk);
      if (integ === 1'b1 && !prev) n++;
      prev = integ;
    end
    check(n, 3);
    check(irq, 0);
    apb(12'h0E0, 1, 32'h3);
    rd(12'h1C0, 33'hE);
    rd(12'h13C, 33'h0);
    print_verdict;
  end
endmodule // test_als_config_range_status_regs
`default_nettype wire
